//--- src/ppap_pkg.sv
package ppap_pkg;
    // --------------------------------------------------------------
    // widths
    // --------------------------------------------------------------
    localparam int SAMPLE_W = 16;
    localparam int HP_W = SAMPLE_W + 1;
    localparam int PROD_W = HP_W + SAMPLE_W;
    localparam int PWR_W = PROD_W + 2;
    localparam int ACC_W = 48;
    localparam int PHASES = 3;

    // --------------------------------------------------------------
    // rates
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int MCLK_HZ = 10_000_000;
    localparam int OSR_HZ = 833_000;
    localparam int BW_HZ = 14_000;
    // decimated rate is twice the bandwidth: 833 kHz / 29 = 28.7 kHz
    localparam int DEC_CNT = OSR_HZ / (2 * BW_HZ);
    localparam int DEC_CNT_W = 5;
    localparam logic [DEC_CNT_W-1:0] DEC_LAST = 5'(DEC_CNT - 1);
    localparam int DEC_SUM_W = SAMPLE_W + DEC_CNT_W;
    localparam int DEC_SHIFT = 5;

    // --------------------------------------------------------------
    // filters
    // --------------------------------------------------------------
    localparam int LPF_CORNER_HZ = 8;
    // single pole at fs/(2*pi*2^k); 28.7 kHz and k=9 gives about 8.9 Hz
    localparam int LPF_SHIFT = 9;
    // dc blocker corner sits near 1.1 Hz, well below the line
    localparam int HPF_SHIFT = 12;

    // --------------------------------------------------------------
    // frequency conversion
    // --------------------------------------------------------------
    localparam logic [ACC_W-1:0] LF_THR_BASE = 48'h0000_4000_0000;
    localparam int CF_RATIO_SH = 7;
    localparam int LF_PULSE_NS = 100_000_000;
    localparam int LF_PULSE_CYC_DEF = LF_PULSE_NS / CLK_PERIOD_NS;
    localparam int CF_PULSE_NS = 90_000;
    localparam int CF_PULSE_CYC = (CF_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CNT_W = 24;

    typedef enum {LP_IDLE, LP_ONE, LP_TWO} ppap_lp_state_t;
endpackage

//--- src/ppap_pole.sv
`timescale 1ns/1ps
// single-pole low pass, y += (x - y) / 2^SHIFT
module ppap_pole #(
    parameter int W = 16,
    parameter int SHIFT = 9
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic signed [W-1:0] x_i,
    output logic signed [W-1:0] y_o
);
    logic signed [W+SHIFT-1:0] state_r;
    logic signed [W+SHIFT:0] diff;

    // fraction bits kept so small inputs still move the state
    assign diff = {x_i[W-1], x_i, {SHIFT{1'b0}}} - {state_r[W+SHIFT-1], state_r};

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_r <= '0;
        end else if (en_i) begin
            state_r <= state_r + (W+SHIFT)'(diff >>> SHIFT);
        end
    end

    assign y_o = state_r[W+SHIFT-1:SHIFT];
endmodule

//--- src/ppap_core.sv
`timescale 1ns/1ps
// Behaviour
// [RL1] take six signed 16-bit oversampled channels
// [RL2] dc blocker on currents only
// [RL3] multiply each current by same-phase voltage
// [RL4] low pass each phase product separately
// [RL5] total power is sum of three phases
// [RL6] long accumulation drives low-rate pulses
// [RL7] short accumulation drives calibration pulse
// [RL8] processing rate gives 14 kHz bandwidth
// [RL9] same-letter wiring; any two phases suffice
// [RL10] power filter is first order, 8 Hz
// [RL11] two selects pick one of four scalings
// [RL12] signed arithmetic; negative power subtracts
module ppap_core import ppap_pkg::*; #(
    parameter int LF_PULSE_CYC = LF_PULSE_CYC_DEF
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic sample_valid_i,
    input wire logic signed [SAMPLE_W-1:0] cur_a_i,
    input wire logic signed [SAMPLE_W-1:0] cur_b_i,
    input wire logic signed [SAMPLE_W-1:0] cur_c_i,
    input wire logic signed [SAMPLE_W-1:0] volt_a_i,
    input wire logic signed [SAMPLE_W-1:0] volt_b_i,
    input wire logic signed [SAMPLE_W-1:0] volt_c_i,
    input wire logic freq_scale_sel_lo_i,
    input wire logic freq_scale_sel_hi_i,
    output logic signed [PWR_W-1:0] total_power_o,
    output logic power_valid_o,
    output logic low_rate_pulse_out_one_o,
    output logic low_rate_pulse_out_two_o,
    output logic calibration_pulse_out_o
);
    // ----------------------------------------------------------
    // threshold decode
    // ----------------------------------------------------------
    function automatic logic [ACC_W-1:0] lf_thr(input logic [1:0] sel);
        lf_thr = LF_THR_BASE >> sel;
    endfunction

    // ----------------------------------------------------------
    // decimation
    // ----------------------------------------------------------
    logic signed [SAMPLE_W-1:0] cur_in [PHASES];
    logic signed [SAMPLE_W-1:0] volt_in [PHASES];
    logic signed [DEC_SUM_W-1:0] cur_sum_r [PHASES];
    logic signed [DEC_SUM_W-1:0] volt_sum_r [PHASES];
    logic signed [SAMPLE_W-1:0] cur_dec_r [PHASES];
    logic signed [SAMPLE_W-1:0] volt_dec_r [PHASES];
    logic [DEC_CNT_W-1:0] dec_cnt_r;
    logic tick0_r;
    logic tick1_r;
    logic tick2_r;

    assign cur_in[0] = cur_a_i;
    assign cur_in[1] = cur_b_i;
    assign cur_in[2] = cur_c_i;
    assign volt_in[0] = volt_a_i;
    assign volt_in[1] = volt_b_i;
    assign volt_in[2] = volt_c_i;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            dec_cnt_r <= '0;
            tick0_r <= 1'b0;
        end else begin
            tick0_r <= 1'b0;
            if (sample_valid_i) begin
                if (dec_cnt_r == DEC_LAST) begin
                    dec_cnt_r <= '0;
                    tick0_r <= 1'b1; // see [RL8]
                end else begin
                    dec_cnt_r <= dec_cnt_r + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            tick1_r <= 1'b0;
            tick2_r <= 1'b0;
            power_valid_o <= 1'b0;
        end else begin
            tick1_r <= tick0_r;
            tick2_r <= tick1_r;
            power_valid_o <= tick2_r;
        end
    end

    // ----------------------------------------------------------
    // per-phase path
    // ----------------------------------------------------------
    logic signed [SAMPLE_W-1:0] cur_dc [PHASES];
    logic signed [PROD_W-1:0] prod_r [PHASES];
    logic signed [PROD_W-1:0] phase_pwr [PHASES];

    genvar g;
    generate
        for (g = 0; g < PHASES; g++) begin : g_phase
            logic signed [DEC_SUM_W-1:0] cur_ext;
            logic signed [DEC_SUM_W-1:0] volt_ext;
            logic signed [HP_W-1:0] cur_hp;

            assign cur_ext = DEC_SUM_W'(cur_in[g]);
            assign volt_ext = DEC_SUM_W'(volt_in[g]);

            // boxcar over one decimation period also limits the bandwidth
            always_ff @(posedge core_clk_i) begin
                if (rst_i) begin
                    cur_sum_r[g] <= '0;
                    volt_sum_r[g] <= '0;
                    cur_dec_r[g] <= '0;
                    volt_dec_r[g] <= '0;
                end else if (sample_valid_i) begin
                    if (dec_cnt_r == DEC_LAST) begin
                        cur_sum_r[g] <= '0;
                        volt_sum_r[g] <= '0;
                        cur_dec_r[g] <= SAMPLE_W'((cur_sum_r[g] + cur_ext) >>> DEC_SHIFT); // see [RL1]
                        volt_dec_r[g] <= SAMPLE_W'((volt_sum_r[g] + volt_ext) >>> DEC_SHIFT); // see [RL1]
                    end else begin
                        cur_sum_r[g] <= cur_sum_r[g] + cur_ext;
                        volt_sum_r[g] <= volt_sum_r[g] + volt_ext;
                    end
                end
            end

            // dc estimate tracked slowly, then removed from the current
            ppap_pole #(.W(SAMPLE_W), .SHIFT(HPF_SHIFT)) u_dc (
                .core_clk_i(core_clk_i),
                .rst_i(rst_i),
                .en_i(tick0_r),
                .x_i(cur_dec_r[g]),
                .y_o(cur_dc[g])
            );
            assign cur_hp = HP_W'(cur_dec_r[g]) - HP_W'(cur_dc[g]); // see [RL2]

            // voltage enters unfiltered; letters match by wiring
            always_ff @(posedge core_clk_i) begin
                if (rst_i) begin
                    prod_r[g] <= '0;
                end else if (tick0_r) begin
                    prod_r[g] <= PROD_W'(cur_hp * volt_dec_r[g]); // see [RL3] see [RL9] see [RL12]
                end
            end

            ppap_pole #(.W(PROD_W), .SHIFT(LPF_SHIFT)) u_pwr (
                .core_clk_i(core_clk_i),
                .rst_i(rst_i),
                .en_i(tick1_r), // see [RL4] see [RL10]
                .x_i(prod_r[g]),
                .y_o(phase_pwr[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------
    // phase sum
    // ----------------------------------------------------------
    // an unused phase reads zero, so any two phases give the same total
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            total_power_o <= '0;
        end else if (tick2_r) begin
            total_power_o <= PWR_W'(phase_pwr[0]) + PWR_W'(phase_pwr[1]) + PWR_W'(phase_pwr[2]); // see [RL5] see [RL9]
        end
    end

    // ----------------------------------------------------------
    // frequency conversion
    // ----------------------------------------------------------
    logic [1:0] scale_sel;
    logic [ACC_W-1:0] lf_limit;
    logic [ACC_W-1:0] cf_limit;
    logic signed [ACC_W-1:0] lf_acc_r;
    logic signed [ACC_W-1:0] cf_acc_r;
    logic signed [ACC_W-1:0] lf_sum;
    logic signed [ACC_W-1:0] cf_sum;
    logic lf_hit;
    logic cf_hit;

    assign scale_sel = {freq_scale_sel_hi_i, freq_scale_sel_lo_i};
    assign lf_limit = lf_thr(scale_sel); // see [RL11]
    assign cf_limit = lf_thr(scale_sel) >> CF_RATIO_SH; // see [RL7]
    assign lf_sum = lf_acc_r + ACC_W'(total_power_o);
    assign cf_sum = cf_acc_r + ACC_W'(total_power_o);
    assign lf_hit = power_valid_o && (lf_sum >= $signed(lf_limit));
    assign cf_hit = power_valid_o && (cf_sum >= $signed(cf_limit));

    // negative totals wind the accumulators back; no pulse below zero
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            lf_acc_r <= '0;
        end else if (power_valid_o) begin
            lf_acc_r <= lf_hit ? lf_sum - $signed(lf_limit) : lf_sum; // see [RL6] see [RL12]
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cf_acc_r <= '0;
        end else if (power_valid_o) begin
            cf_acc_r <= cf_hit ? cf_sum - $signed(cf_limit) : cf_sum; // see [RL7]
        end
    end

    // ----------------------------------------------------------
    // pulse outputs
    // ----------------------------------------------------------
    // low-rate pulses alternate between the two outputs for a stepper;
    // a crossing during a running pulse is dropped, limiting max rate
    ppap_lp_state_t lp_state_r;
    logic lp_next_two_r;
    logic [PULSE_CNT_W-1:0] lp_cnt_r;
    logic [PULSE_CNT_W-1:0] cf_cnt_r;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            lp_state_r <= LP_IDLE;
            lp_next_two_r <= 1'b0;
            lp_cnt_r <= '0;
        end else begin
            case (lp_state_r)
                LP_IDLE: begin
                    if (lf_hit) begin
                        lp_state_r <= lp_next_two_r ? LP_TWO : LP_ONE; // see [RL6]
                        lp_next_two_r <= ~lp_next_two_r;
                        lp_cnt_r <= PULSE_CNT_W'(LF_PULSE_CYC - 1);
                    end
                end
                LP_ONE, LP_TWO: begin
                    if (lp_cnt_r == '0) begin
                        lp_state_r <= LP_IDLE;
                    end else begin
                        lp_cnt_r <= lp_cnt_r - 24'h000001;
                    end
                end
                default: begin
                    lp_state_r <= LP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            low_rate_pulse_out_one_o <= 1'b0;
            low_rate_pulse_out_two_o <= 1'b0;
        end else begin
            low_rate_pulse_out_one_o <= (lp_state_r == LP_ONE);
            low_rate_pulse_out_two_o <= (lp_state_r == LP_TWO);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cf_cnt_r <= '0;
            calibration_pulse_out_o <= 1'b0;
        end else if (cf_cnt_r != '0) begin
            cf_cnt_r <= cf_cnt_r - 24'h000001;
            calibration_pulse_out_o <= (cf_cnt_r != 24'h000001);
        end else if (cf_hit) begin
            cf_cnt_r <= PULSE_CNT_W'(CF_PULSE_CYC); // see [RL7]
            calibration_pulse_out_o <= 1'b1;
        end else begin
            calibration_pulse_out_o <= 1'b0;
        end
    end
endmodule

//--- tb/ppap_core_properties.sv
`timescale 1ns/1ps
module ppap_core_properties import ppap_pkg::*; #(
    parameter int LF_PULSE_CYC = LF_PULSE_CYC_DEF
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic signed [PWR_W-1:0] total_power_o,
    input wire logic power_valid_o,
    input wire logic low_rate_pulse_out_one_o,
    input wire logic low_rate_pulse_out_two_o,
    input wire logic calibration_pulse_out_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    int gap_r;
    int cf_w_r;
    int lf_w_r;
    logic seen_r;
    logic one_last_r;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            gap_r <= 0;
            cf_w_r <= 0;
            lf_w_r <= 0;
            seen_r <= 1'b0;
            one_last_r <= 1'b0;
        end else begin
            gap_r <= power_valid_o ? 0 : gap_r + 1;
            seen_r <= seen_r | power_valid_o;
            cf_w_r <= calibration_pulse_out_o ? cf_w_r + 1 : 0;
            lf_w_r <= low_rate_pulse_out_one_o ? lf_w_r + 1 : 0;
            one_last_r <= low_rate_pulse_out_one_o | (one_last_r & !low_rate_pulse_out_two_o);
        end
    end
    // 29 strobes cannot arrive in fewer than 29 cycles
    valid_spacing_a: assert property (power_valid_o && seen_r |-> gap_r >= 28) else $error("valid too soon");
    valid_pulse_a: assert property (power_valid_o |=> !power_valid_o) else $error("valid held");
    total_hold_a: assert property (!power_valid_o |-> $stable(total_power_o)) else $error("total moved");
    cf_cause_a: assert property ($rose(calibration_pulse_out_o) |-> $past(power_valid_o))
        else $error("cf without update");
    lf_cause_a: assert property ($rose(low_rate_pulse_out_one_o) || $rose(low_rate_pulse_out_two_o)
        |-> $past(power_valid_o, 2)) else $error("lf without update");
    cf_width_a: assert property ($fell(calibration_pulse_out_o) |-> cf_w_r == CF_PULSE_CYC)
        else $error("cf width");
    lf_width_a: assert property ($fell(low_rate_pulse_out_one_o) |-> lf_w_r == LF_PULSE_CYC)
        else $error("lf width");
    lf_order_a: assert property ($rose(low_rate_pulse_out_one_o) || $rose(low_rate_pulse_out_two_o)
        |-> $rose(low_rate_pulse_out_one_o) != one_last_r) else $error("lf order");
endmodule
bind ppap_core ppap_core_properties #(.LF_PULSE_CYC(LF_PULSE_CYC)) u_ppap_core_properties (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .total_power_o(total_power_o),
    .power_valid_o(power_valid_o),
    .low_rate_pulse_out_one_o(low_rate_pulse_out_one_o),
    .low_rate_pulse_out_two_o(low_rate_pulse_out_two_o),
    .calibration_pulse_out_o(calibration_pulse_out_o)
);

//--- tb/ppap_adc_model.sv
`timescale 1ns/1ps
// front-end modulators plus a pulse counter; square waves flip every 116 strobes
module ppap_adc_model import ppap_pkg::*; (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [5:0][SAMPLE_W-1:0] amp_i,
    input wire logic lf_one_i,
    input wire logic lf_two_i,
    input wire logic cf_i,
    output logic strobe_o = 1'b0,
    output logic [5:0][SAMPLE_W-1:0] smp_o = '0,
    output int lf_one_n_o = 0,
    output int lf_two_n_o = 0,
    output int cf_n_o = 0
);
    int cyc = 0;
    int nstr = 0;
    logic s;
    logic [SAMPLE_W-1:0] v;
    always @(negedge core_clk_i) begin
        s = !rst_i && cyc == 0;
        cyc = rst_i ? 0 : (cyc + 1) % 4;
        nstr = rst_i ? 0 : nstr;
        strobe_o <= s;
        for (int k = 0; k < 6; k++) begin
            v = ((nstr / 116) % 2) ? -amp_i[k] : amp_i[k];
            // lines outside a strobe carry junk so stale data is never trusted
            smp_o[k] <= s ? v : ~v;
        end
        nstr = nstr + s;
    end
    // previous levels start at the idle low so reset never counts a false edge
    logic lf_one_q = 1'b0;
    logic lf_two_q = 1'b0;
    logic cf_q = 1'b0;
    always @(posedge core_clk_i) begin
        lf_one_q <= rst_i ? 1'b0 : lf_one_i;
        lf_two_q <= rst_i ? 1'b0 : lf_two_i;
        cf_q <= rst_i ? 1'b0 : cf_i;
        lf_one_n_o <= rst_i ? 0 : lf_one_n_o + int'(lf_one_i && !lf_one_q);
        lf_two_n_o <= rst_i ? 0 : lf_two_n_o + int'(lf_two_i && !lf_two_q);
        cf_n_o <= rst_i ? 0 : cf_n_o + int'(cf_i && !cf_q);
    end
endmodule

//--- tb/ppap_core_test.sv
`timescale 1ns/1ps
module ppap_core_test import ppap_pkg::*;;
    localparam logic [15:0] POS = 16'h3E80;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sel_lo = 1'b0;
    logic sel_hi = 1'b0;
    logic [5:0][SAMPLE_W-1:0] amp = '0;
    logic strobe;
    logic [5:0][SAMPLE_W-1:0] smp;
    logic signed [PWR_W-1:0] total;
    logic signed [PWR_W-1:0] ref_p;
    logic pv;
    logic lf1;
    logic lf2;
    logic cf;
    int n1;
    int n2;
    int nc;
    int prev;
    int n_fail = 0;
    int comparisons = 0;
    always #50 core_clk_i = ~core_clk_i;
    ppap_core #(.LF_PULSE_CYC(20)) u_ppap_core (.core_clk_i(core_clk_i), .rst_i(rst_i), .sample_valid_i(strobe),
        .cur_a_i(smp[0]), .cur_b_i(smp[1]), .cur_c_i(smp[2]), .volt_a_i(smp[3]), .volt_b_i(smp[4]),
        .volt_c_i(smp[5]), .freq_scale_sel_lo_i(sel_lo), .freq_scale_sel_hi_i(sel_hi), .total_power_o(total),
        .power_valid_o(pv), .low_rate_pulse_out_one_o(lf1), .low_rate_pulse_out_two_o(lf2),
        .calibration_pulse_out_o(cf));
    ppap_adc_model u_ppap_adc_model (.core_clk_i(core_clk_i), .rst_i(rst_i), .amp_i(amp), .lf_one_i(lf1),
        .lf_two_i(lf2), .cf_i(cf), .strobe_o(strobe), .smp_o(smp), .lf_one_n_o(n1), .lf_two_n_o(n2), .cf_n_o(nc));
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input bit ok, input string msg);
        comparisons++;
        if (!ok) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    function automatic logic [5:0][SAMPLE_W-1:0] mk(input int ci, input int vi, input logic [15:0] va);
        mk = '0;
        mk[ci] = POS;
        mk[vi + 3] = va;
    endfunction
    // reset, then run 50 decimated updates; the last gap must be 29 strobes of 4 cycles
    task automatic run(input logic [5:0][SAMPLE_W-1:0] a, input logic [1:0] sel);
        int w;
        @(negedge core_clk_i);
        rst_i <= 1'b1;
        amp <= a;
        {sel_hi, sel_lo} <= sel;
        repeat (6) @(negedge core_clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 50; k++) begin
            w = 0;
            do begin
                @(negedge core_clk_i);
                w++;
            end while (pv !== 1'b1 && w < 400);
            chk(w < 400, "no power update");
            if (w >= 400) finish_test();
        end
        chk(w === 116, "update period");
    endtask
    task automatic t_phase_a();
        run(mk(0, 0, POS), 2'h3);
        ref_p = total;
        chk(ref_p > 0 && nc > 0, "phase a power or cf");
        chk(n1 > 0 && (n1 - n2 == 0 || n1 - n2 == 1), "lf count");
    endtask
    task automatic t_letters();
        for (int p = 1; p < 3; p++) begin
            run(mk(p, p, POS), 2'h3);
            chk(total === ref_p, "phase letter mismatch");
        end
    endtask
    task automatic t_sum();
        run(mk(0, 0, POS) | mk(1, 1, POS), 2'h3);
        chk(total === 2 * ref_p, "phase sum");
    endtask
    task automatic t_cross();
        run(mk(0, 1, POS), 2'h3);
        chk(total === 0 && nc === 0 && n1 === 0, "cross phase product");
    endtask
    task automatic t_negative();
        run(mk(0, 0, -POS), 2'h3);
        chk(total < 0 && n1 + n2 + nc === 0, "negative power");
    endtask
    // a larger select divides the threshold, so pulses never get fewer
    task automatic t_scale();
        prev = -1;
        for (int s = 0; s < 4; s++) begin
            run(mk(0, 0, POS), 2'(s));
            chk(n1 + n2 >= prev && (s < 3 || n1 + n2 > prev), "scale order");
            prev = (s == 0) ? n1 + n2 : prev;
            prev = (s > 0 && s < 3) ? n1 + n2 : prev;
        end
    endtask
    initial begin
        t_phase_a();
        t_letters();
        t_sum();
        t_cross();
        t_negative();
        t_scale();
        finish_test();
    end
endmodule
